// >>> common/pss_defines.vh
// Constants shared by the port split link supervisor design files.
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define PSS_OFS_SPLIT_ENABLE    16'h3c48
`define PSS_OFS_P3_PIN_SELECT   16'h416e
`define PSS_OFS_P4_PIN_SELECT   16'h416f
`define PSS_OFS_LINK_TIMEOUT    16'h4171
`define PSS_OFS_TOGGLE_DURATION 16'h4176
`define PSS_OFS_SPLIT_STATUS    16'h4177

// ****************************************
// Reset values
// ****************************************
`define PSS_RST_SPLIT_ENABLE    8'h00
`define PSS_RST_PIN_SELECT      8'h00
`define PSS_RST_LINK_TIMEOUT    8'h05
`define PSS_RST_TOGGLE_DURATION 8'h05

// ****************************************
// Field positions and codes
// ****************************************
`define PSS_BIT_EN_PORT3        5
`define PSS_BIT_EN_PORT4        6
`define PSS_TIMEOUT_MSB         2
`define PSS_SEL_P3_OPTION_A     8'h42
`define PSS_SEL_P3_OPTION_B     8'h05
`define PSS_SEL_P4_OPTION_A     8'h06
`define PSS_SEL_P4_OPTION_B     8'h04
`define PSS_LTSSM_STUCK_LO      4'h4
`define PSS_LTSSM_STUCK_HI      4'h9

// ****************************************
// Timing
// ****************************************
`define PSS_CLK_MHZ             50
`define PSS_TICK_US             1000
`define PSS_TICK_CYCLES         (`PSS_TICK_US * `PSS_CLK_MHZ)
`define PSS_TMO_CODE1_MS        12'h064
`define PSS_TMO_CODE2_MS        12'h0fa
`define PSS_TMO_CODE3_MS        12'h1f4
`define PSS_TMO_CODE4_MS        12'h2ee
`define PSS_TMO_CODE5_MS        12'h3e8
`define PSS_TMO_CODE6_MS        12'h7d0
`define PSS_TOGGLE_BASE_MS      12'h15e
`define PSS_TOGGLE_STEP_MS      4'ha

`endif

// >>> rtl/pss_port_seq.v
// Per-port stuck-link timer and split power toggle sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "pss_defines.vh"

module pss_port_seq (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire        ms_tick,
  input  wire        split_on,
  input  wire [3:0]  ltssm_state,
  input  wire [11:0] timeout_ms,
  input  wire [11:0] low_ms,
  output reg         power_on,
  output reg         toggling
);

  localparam [0:0] ST_WATCH = 1'b0;
  localparam [0:0] ST_LOW   = 1'b1;

  reg [0:0]  state_reg;
  reg [0:0]  state_next;
  reg [11:0] cnt_reg;
  reg [11:0] cnt_next;
  reg [3:0]  last_ltssm_reg;
  wire       in_stuck_set;
  wire       stuck;
  wire [12:0] cnt_inc;

  // A state counts as stuck only while it is in the bad range and unchanged.
  assign in_stuck_set = (ltssm_state >= `PSS_LTSSM_STUCK_LO) &&
                        (ltssm_state <= `PSS_LTSSM_STUCK_HI);
  assign stuck   = in_stuck_set && (ltssm_state == last_ltssm_reg);
  assign cnt_inc = {1'b0, cnt_reg} + 13'h0001;

  // Next-state logic of the watch and low-pulse sequence.
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_WATCH: begin
        if (!split_on || (timeout_ms == 12'h000) || !stuck) begin
          cnt_next = 12'h000;
        end else if (ms_tick) begin
          if (cnt_inc >= {1'b0, timeout_ms}) begin
            state_next = ST_LOW;
            cnt_next   = 12'h000;
          end else begin
            cnt_next = cnt_inc[11:0];
          end
        end
      end
      ST_LOW: begin
        if (!split_on) begin
          state_next = ST_WATCH;
          cnt_next   = 12'h000;
        end else if (ms_tick) begin
          if (cnt_inc >= {1'b0, low_ms}) begin
            state_next = ST_WATCH;
            cnt_next   = 12'h000;
          end else begin
            cnt_next = cnt_inc[11:0];
          end
        end
      end
      default: begin
        state_next = ST_WATCH;
        cnt_next   = 12'h000;
      end
    endcase
  end

  // State, counter and registered pin level.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg      <= ST_WATCH;
      cnt_reg        <= 12'h000;
      last_ltssm_reg <= 4'h0;
      power_on       <= 1'b1;
      toggling       <= 1'b0;
    end else begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      last_ltssm_reg <= ltssm_state;
      power_on       <= (state_next != ST_LOW);
      toggling       <= (state_next == ST_LOW);
    end
  end

endmodule // pss_port_seq

`default_nettype wire

// >>> rtl/pss_top.v
// Port split supervisor: configuration registers, pin routing and two port sequencers.
`timescale 1ns/100ps
`default_nettype none
`include "pss_defines.vh"

module pss_top #(
  parameter TICK_CYCLES = `PSS_TICK_CYCLES
) (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire [15:0] cfg_addr,
  input  wire        cfg_wr,
  input  wire        cfg_rd,
  input  wire [7:0]  cfg_wdata,
  output reg  [7:0]  cfg_rdata,
  input  wire        otp_load,
  input  wire [7:0]  otp_split_enable,
  input  wire [7:0]  otp_p3_pin_select,
  input  wire [7:0]  otp_p4_pin_select,
  input  wire [7:0]  otp_link_timeout,
  input  wire [7:0]  otp_toggle_duration,
  input  wire [3:0]  ltssm_state_p3,
  input  wire [3:0]  ltssm_state_p4,
  input  wire [1:0]  usb2_power_req,
  output reg  [1:0]  port_power_ctl_pin,
  output reg         port3_option_a_pin_out,
  output reg         port3_option_a_pin_oe,
  output reg         port3_option_b_pin_out,
  output reg         port3_option_b_pin_oe,
  output reg         port4_option_a_pin_out,
  output reg         port4_option_a_pin_oe,
  output reg         port4_option_b_pin_out,
  output reg         port4_option_b_pin_oe
);

  // ****************************************
  // Configuration registers
  // ****************************************

  reg  [1:0]  split_en_reg;
  reg  [7:0]  p3_sel_reg;
  reg  [7:0]  p4_sel_reg;
  reg  [2:0]  timeout_reg;
  reg  [7:0]  toggle_reg;
  wire        wr_enable;
  wire        wr_p3_sel;
  wire        wr_p4_sel;
  wire        wr_timeout;
  wire        wr_toggle;

  // Reset images held as vectors so that single fields can be picked from them.
  localparam [7:0] RST_ENABLE  = `PSS_RST_SPLIT_ENABLE;
  localparam [7:0] RST_TIMEOUT = `PSS_RST_LINK_TIMEOUT;

  // Address decode for configuration-stage writes.
  assign wr_enable  = cfg_wr && (cfg_addr == `PSS_OFS_SPLIT_ENABLE);
  assign wr_p3_sel  = cfg_wr && (cfg_addr == `PSS_OFS_P3_PIN_SELECT);
  assign wr_p4_sel  = cfg_wr && (cfg_addr == `PSS_OFS_P4_PIN_SELECT);
  assign wr_timeout = cfg_wr && (cfg_addr == `PSS_OFS_LINK_TIMEOUT);
  assign wr_toggle  = cfg_wr && (cfg_addr == `PSS_OFS_TOGGLE_DURATION);

  // Register storage; an OTP load takes priority over a same-cycle write.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      split_en_reg <= {RST_ENABLE[`PSS_BIT_EN_PORT4],
                       RST_ENABLE[`PSS_BIT_EN_PORT3]};
      p3_sel_reg   <= `PSS_RST_PIN_SELECT;
      p4_sel_reg   <= `PSS_RST_PIN_SELECT;
      timeout_reg  <= RST_TIMEOUT[`PSS_TIMEOUT_MSB:0];
      toggle_reg   <= `PSS_RST_TOGGLE_DURATION;
    end else if (otp_load) begin
      // Only the bits of ports 3 and 4 exist; the rest are not stored.
      split_en_reg <= {otp_split_enable[`PSS_BIT_EN_PORT4],
                       otp_split_enable[`PSS_BIT_EN_PORT3]};
      p3_sel_reg   <= otp_p3_pin_select;
      p4_sel_reg   <= otp_p4_pin_select;
      timeout_reg  <= otp_link_timeout[`PSS_TIMEOUT_MSB:0];
      toggle_reg   <= otp_toggle_duration;
    end else begin
      if (wr_enable) begin
        split_en_reg <= {cfg_wdata[`PSS_BIT_EN_PORT4],
                         cfg_wdata[`PSS_BIT_EN_PORT3]};
      end
      if (wr_p3_sel) begin
        p3_sel_reg <= cfg_wdata;
      end
      if (wr_p4_sel) begin
        p4_sel_reg <= cfg_wdata;
      end
      if (wr_timeout) begin
        timeout_reg <= cfg_wdata[`PSS_TIMEOUT_MSB:0];
      end
      if (wr_toggle) begin
        toggle_reg <= cfg_wdata;
      end
    end
  end

  // ****************************************
  // Register read port
  // ****************************************

  wire [1:0] toggling;

  // Read data is registered; reserved bits and unmapped addresses read zero.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      case (cfg_addr)
        `PSS_OFS_SPLIT_ENABLE: begin
          cfg_rdata <= {1'b0, split_en_reg, 5'h00};
        end
        `PSS_OFS_P3_PIN_SELECT: begin
          cfg_rdata <= p3_sel_reg;
        end
        `PSS_OFS_P4_PIN_SELECT: begin
          cfg_rdata <= p4_sel_reg;
        end
        `PSS_OFS_LINK_TIMEOUT: begin
          cfg_rdata <= {5'h00, timeout_reg};
        end
        `PSS_OFS_TOGGLE_DURATION: begin
          cfg_rdata <= toggle_reg;
        end
        `PSS_OFS_SPLIT_STATUS: begin
          cfg_rdata <= {6'h00, toggling};
        end
        default: begin
          cfg_rdata <= 8'h00;
        end
      endcase
    end
  end

  // ****************************************
  // Millisecond time base
  // ****************************************

  reg  [16:0] tick_cnt_reg;
  reg         ms_tick_reg;
  // The divider limit is cut to the counter width on purpose.
  localparam integer TICK_LAST_FULL = TICK_CYCLES - 1;
  localparam [16:0]  TICK_LAST      = TICK_LAST_FULL[16:0];

  // Divider that gives a one-cycle enable every millisecond.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_reg <= 17'h00000;
      ms_tick_reg  <= 1'b0;
    end else if (tick_cnt_reg >= TICK_LAST) begin
      tick_cnt_reg <= 17'h00000;
      ms_tick_reg  <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 17'h00001;
      ms_tick_reg  <= 1'b0;
    end
  end

  // ****************************************
  // Timeout and low-time decode
  // ****************************************

  reg  [11:0] timeout_ms;
  wire [11:0] low_ms;

  // One global timeout figure for both ports; code 000 and 111 never toggle.
  always @* begin
    case (timeout_reg)
      3'h1: begin
        timeout_ms = `PSS_TMO_CODE1_MS;
      end
      3'h2: begin
        timeout_ms = `PSS_TMO_CODE2_MS;
      end
      3'h3: begin
        timeout_ms = `PSS_TMO_CODE3_MS;
      end
      3'h4: begin
        timeout_ms = `PSS_TMO_CODE4_MS;
      end
      3'h5: begin
        timeout_ms = `PSS_TMO_CODE5_MS;
      end
      3'h6: begin
        timeout_ms = `PSS_TMO_CODE6_MS;
      end
      default: begin
        timeout_ms = 12'h000;
      end
    endcase
  end

  // Low time is the base plus ten milliseconds per step of the field.
  assign low_ms = `PSS_TOGGLE_BASE_MS + toggle_reg * `PSS_TOGGLE_STEP_MS;

  // ****************************************
  // Per-port sequencers
  // ****************************************

  wire [1:0] split_power_on;
  wire [7:0] ltssm_vec;

  assign ltssm_vec = {ltssm_state_p4, ltssm_state_p3};

  // Only ports 3 and 4 have a sequencer; index 0 is port 3, index 1 port 4.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_port
      pss_port_seq u_seq (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .ms_tick     (ms_tick_reg),
        .split_on    (split_en_reg[gi]),
        .ltssm_state (ltssm_vec[gi*4 +: 4]),
        .timeout_ms  (timeout_ms),
        .low_ms      (low_ms),
        .power_on    (split_power_on[gi]),
        .toggling    (toggling[gi])
      );
    end
  endgenerate

  // ****************************************
  // Pin routing
  // ****************************************

  // The ordinary power pins follow the USB 2.0 request, split or not.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      port_power_ctl_pin <= 2'b00;
    end else begin
      port_power_ctl_pin <= usb2_power_req;
    end
  end

  // The split pin is driven only on the selected GPIO while splitting is on.
  // The pin is output only: nothing samples it for overcurrent.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      port3_option_a_pin_out <= 1'b0;
      port3_option_a_pin_oe  <= 1'b0;
      port3_option_b_pin_out <= 1'b0;
      port3_option_b_pin_oe  <= 1'b0;
      port4_option_a_pin_out <= 1'b0;
      port4_option_a_pin_oe  <= 1'b0;
      port4_option_b_pin_out <= 1'b0;
      port4_option_b_pin_oe  <= 1'b0;
    end else begin
      port3_option_a_pin_out <= split_power_on[0];
      port3_option_b_pin_out <= split_power_on[0];
      port4_option_a_pin_out <= split_power_on[1];
      port4_option_b_pin_out <= split_power_on[1];
      port3_option_a_pin_oe  <= split_en_reg[0] &&
                                (p3_sel_reg == `PSS_SEL_P3_OPTION_A);
      port3_option_b_pin_oe  <= split_en_reg[0] &&
                                (p3_sel_reg == `PSS_SEL_P3_OPTION_B);
      port4_option_a_pin_oe  <= split_en_reg[1] &&
                                (p4_sel_reg == `PSS_SEL_P4_OPTION_A);
      port4_option_b_pin_oe  <= split_en_reg[1] &&
                                (p4_sel_reg == `PSS_SEL_P4_OPTION_B);
    end
  end

endmodule // pss_top

`default_nettype wire

// >>> verification/pss_link_partner.sv
// Behavioural model of the embedded SuperSpeed device on a split port.
`timescale 1ns/100ps
`default_nettype none
module pss_link_partner (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       power_on,
  input  wire logic       healthy,
  output var  logic [3:0] ltssm_state
);
  // A powered healthy device walks the link states; otherwise the link sits in receiver detect.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ltssm_state <= 4'h5;
    end else if (power_on && healthy) begin
      ltssm_state <= (ltssm_state == 4'hb) ? 4'h0 : ltssm_state + 4'h1;
    end else begin
      ltssm_state <= 4'h5;
    end
  end
endmodule // pss_link_partner
`default_nettype wire

// >>> verification/pss_monitor.sv
// Concurrent checks on the port split supervisor top ports.
`timescale 1ns/100ps
`default_nettype none
module pss_monitor #(
  parameter int TICK_CYCLES = 2
) (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [15:0] cfg_addr,
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_rdata,
  input wire logic [3:0]  ltssm_state_p3,
  input wire logic [1:0]  usb2_power_req,
  input wire logic [1:0]  port_power_ctl_pin,
  input wire logic        port3_option_a_pin_out,
  input wire logic        port3_option_a_pin_oe,
  input wire logic        port3_option_b_pin_oe,
  input wire logic        port4_option_a_pin_oe,
  input wire logic        port4_option_b_pin_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  int stk3;
  int lo3;
  logic bad3;
  logic [3:0] lt3_q;
  assign bad3 = (ltssm_state_p3 >= 4'h4) && (ltssm_state_p3 <= 4'h9);
  // Counts stuck link cycles and low cycles of the port 3 option A pin.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stk3 <= 0;
      lo3 <= 0;
      lt3_q <= 4'h0;
    end else begin
      stk3 <= (bad3 && ltssm_state_p3 == lt3_q) ? stk3 + 1 : 0;
      lo3 <= port3_option_a_pin_out ? 0 : lo3 + 1;
      lt3_q <= ltssm_state_p3;
    end
  end
  sequence s_p3_rise;
    $rose(port3_option_a_pin_out) && port3_option_a_pin_oe;
  endsequence
  sequence s_p3_fall;
    $fell(port3_option_a_pin_out) && port3_option_a_pin_oe;
  endsequence
  AST_USB2_COPY: assert property ($past(rstn) |-> port_power_ctl_pin == $past(usb2_power_req))
    else $error("usb2 power pin does not follow its request");
  AST_P3_ONE_PIN: assert property (!(port3_option_a_pin_oe && port3_option_b_pin_oe))
    else $error("both port 3 split pins driven");
  AST_P4_ONE_PIN: assert property (!(port4_option_a_pin_oe && port4_option_b_pin_oe))
    else $error("both port 4 split pins driven");
  AST_P3_LOW_LEN: assert property (s_p3_rise |-> lo3 >= 350 * TICK_CYCLES)
    else $error("split power low pulse too short");
  AST_P3_LOW_MAX: assert property (port3_option_a_pin_oe |-> lo3 <= 2900 * TICK_CYCLES)
    else $error("split power low pulse too long");
  AST_P3_STUCK: assert property (s_p3_fall |-> stk3 >= 99 * TICK_CYCLES)
    else $error("split power pulse without a stuck link");
  AST_EN_RSVD: assert property ($past(cfg_rd) && $past(cfg_addr) == 16'h3c48 |-> (cfg_rdata & 8'h9f) == 8'h00)
    else $error("reserved enable bits read nonzero");
  AST_TMO_RSVD: assert property ($past(cfg_rd) && $past(cfg_addr) == 16'h4171 |-> cfg_rdata[7:3] == 5'h00)
    else $error("reserved timeout bits read nonzero");
endmodule // pss_monitor
bind pss_top pss_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_pss_monitor (.sys_clk, .rstn, .cfg_addr,
  .cfg_rd, .cfg_rdata, .ltssm_state_p3, .usb2_power_req, .port_power_ctl_pin,
  .port3_option_a_pin_out, .port3_option_a_pin_oe, .port3_option_b_pin_oe,
  .port4_option_a_pin_oe, .port4_option_b_pin_oe);
`default_nettype wire

// >>> verification/test_pss_top.sv
// Self-checking testbench for the port split supervisor.
`timescale 1ns/100ps
`default_nettype none
module test_pss_top;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] cfg_addr = 16'h0000;
  logic        cfg_wr = 1'b0;
  logic        cfg_rd = 1'b0;
  logic [7:0]  cfg_wdata = 8'h00;
  logic [7:0]  cfg_rdata;
  logic        otp_load = 1'b0;
  logic [7:0]  otp_en = 8'h00, otp_s3 = 8'h00, otp_s4 = 8'h00, otp_tmo = 8'h00, otp_tog = 8'h00;
  logic [3:0]  lt3, lt4;
  logic [1:0]  usb2_power_req = 2'b00;
  logic [1:0]  port_power_ctl_pin;
  logic        p3a, p3a_oe, p3b, p3b_oe, p4a, p4a_oe, p4b, p4b_oe;
  logic        ok3 = 1'b0;
  logic [3:0]  oe_vec;
  int          mismatches = 0;
  int          n_checks = 0;
  int          n;
  logic [15:0] sel_addr [5] = '{16'h416e, 16'h416e, 16'h416e, 16'h416f, 16'h416f};
  logic [7:0]  sel_code [5] = '{8'h42, 8'h05, 8'h06, 8'h06, 8'h04};
  logic [3:0]  oe_exp [5] = '{4'h8, 4'h4, 4'h0, 4'h2, 4'h1};
  assign oe_vec = {p3a_oe, p3b_oe, p4a_oe, p4b_oe};
  // Clock of 50 MHz.
  always #10 sys_clk = ~sys_clk;
  pss_top #(.TICK_CYCLES(2)) u_pss_top (.sys_clk, .rstn, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata,
    .cfg_rdata, .otp_load, .otp_split_enable(otp_en), .otp_p3_pin_select(otp_s3),
    .otp_p4_pin_select(otp_s4), .otp_link_timeout(otp_tmo), .otp_toggle_duration(otp_tog),
    .ltssm_state_p3(lt3), .ltssm_state_p4(lt4), .usb2_power_req, .port_power_ctl_pin,
    .port3_option_a_pin_out(p3a), .port3_option_a_pin_oe(p3a_oe), .port3_option_b_pin_out(p3b),
    .port3_option_b_pin_oe(p3b_oe), .port4_option_a_pin_out(p4a), .port4_option_a_pin_oe(p4a_oe),
    .port4_option_b_pin_out(p4b), .port4_option_b_pin_oe(p4b_oe));
  pss_link_partner u_pss_link_partner_p3 (.sys_clk, .rstn, .healthy(ok3), .ltssm_state(lt3),
    .power_on((p3a_oe & p3a) | (p3b_oe & p3b)));
  pss_link_partner u_pss_link_partner_p4 (.sys_clk, .rstn, .healthy(1'b1), .ltssm_state(lt4),
    .power_on((p4a_oe & p4a) | (p4b_oe & p4b)));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    check("cfg_rdata", {8'h00, cfg_rdata}, {8'h00, exp});
  endtask
  // Waits until the port 3 option A pin reaches a level, counting cycles.
  task automatic wait_lvl(input logic lvl, input int lim);
    n = 0;
    while (p3a !== lvl && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence of register accesses and link scenarios.
  initial begin
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    rd(16'h3c48, 8'h00);
    rd(16'h4171, 8'h05);
    rd(16'h4176, 8'h05);
    rd(16'h1234, 8'h00);
    wr(16'h3c48, 8'hff);
    rd(16'h3c48, 8'h60);
    wr(16'h4171, 8'hff);
    rd(16'h4171, 8'h07);
    for (int i = 0; i < 5; i++) begin
      wr(sel_addr[i], sel_code[i]);
      repeat (2) @(negedge sys_clk);
      check("pin_oe", {12'h000, oe_vec}, {12'h000, oe_exp[i]});
    end
    usb2_power_req = 2'b10;
    @(negedge sys_clk);
    check("port_power_ctl_pin", {14'h0, port_power_ctl_pin}, 16'h0002);
    ok3 = 1'b1;
    wr(16'h416e, 8'h42);
    wr(16'h416f, 8'h06);
    wr(16'h4176, 8'h00);
    wr(16'h4171, 8'h01);
    ok3 = 1'b0;
    wait_lvl(1'b0, 260);
    check("first_timeout", {15'h0, n >= 190 && n <= 210}, 16'h0001);
    wait_lvl(1'b1, 800);
    check("low_cycles", n[15:0], 16'd700);
    check("port4_pin", {15'h0, p4a}, 16'h0001);
    wait_lvl(1'b0, 260);
    check("repeat_timeout", {15'h0, n >= 190 && n <= 210}, 16'h0001);
    rd(16'h4177, 8'h01);
    wait_lvl(1'b1, 800);
    wr(16'h4171, 8'h00);
    wait_lvl(1'b0, 600);
    check("no_toggle", n[15:0], 16'd600);
    {otp_en, otp_s3, otp_s4, otp_tmo, otp_tog} = 40'h20_05_00_02_01;
    otp_load = 1'b1;
    @(negedge sys_clk);
    otp_load = 1'b0;
    rd(16'h4171, 8'h02);
    rd(16'h3c48, 8'h20);
    check("pin_oe", {12'h000, oe_vec}, 16'h0004);
    check("b_pins_out", {14'h0, p3b, p4b}, 16'h0003);
    end_of_test();
  end
  // Cuts a hung run short.
  initial begin
    repeat (20000) @(negedge sys_clk);
    mismatches++;
    end_of_test();
  end
endmodule // test_pss_top
`default_nettype wire
